//--- include/tuart_defines.svh
// constants of the triple serial port block
//
// Notes on behaviour
// RULE1: the primary port runs at 4800 to 921600 bps in nine steps and comes up at 115200 bps until another rate is loaded.
// RULE2: the log port runs at 115200, 3000000 or 6000000 bps, comes up at 6000000 bps and carries log output.
// RULE3: the primary port paces both directions with a request-to-send and clear-to-send pair shared with the host.
// RULE4: the module drives the primary clear-to-send line to tell the host whether it may send.
// RULE5: the host drives the primary request-to-send line into the module to show it is ready, wired straight, not crossed.
// RULE6: in sleep, a falling edge on the primary receive line raises a wake-up pulse when wake is enabled.
// RULE7: above 9600 bps the character that caused the wake-up is dropped and only the wake-up takes effect.
// RULE8: the host is advised to implement the flow-control handshake on the primary port.
// RULE9: every port frames one low start bit, eight data bits least significant first, no parity, one high stop bit, idle high.
`ifndef TUART_DEFINES_SVH
`define TUART_DEFINES_SVH

// ----------------------------------------------------------------
// clock and rates
// ----------------------------------------------------------------
`define TU_CLK_HZ 250000000
`define TU_DIV(b) (`TU_CLK_HZ / (b))
`define TU_BAUD_4800 4800
`define TU_BAUD_9600 9600
`define TU_BAUD_19200 19200
`define TU_BAUD_38400 38400
`define TU_BAUD_57600 57600
`define TU_BAUD_115200 115200
`define TU_BAUD_230400 230400
`define TU_BAUD_460800 460800
`define TU_BAUD_921600 921600
`define TU_BAUD_3M 3000000
`define TU_BAUD_6M 6000000

// ----------------------------------------------------------------
// selects, framing, ports
// ----------------------------------------------------------------
`define TU_MAIN_SEL_RST 4'h5
`define TU_MAIN_SEL_9600 4'h1
`define TU_LOG_SEL_RST 2'h2
`define TU_STOP_BIT 4'h9
`define TU_FIFO_WIDTH 8
`define TU_FIFO_DEPTH 32
`define TU_CTS_STOP_LEVEL 6'h1C
`define TU_PORT_MAIN 0
`define TU_PORT_LOG 1
`define TU_PORT_AUX 2
`define TU_SYNC_RTS 3

`endif

//--- include/tuart_pkg.sv
// types of the triple serial port block
package tuart_pkg;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } tuart_byte_t;

   typedef struct packed {
      logic idle;
      logic [15:0] cnt;
      logic [3:0] bitNum;
      logic [8:0] shift;
      logic line;
   } tuart_tx_t;

   typedef struct packed {
      logic busy;
      logic [15:0] cnt;
      logic [3:0] bitNum;
      logic [7:0] shift;
      logic done;
      logic frameErr;
      logic [7:0] data;
   } tuart_rx_t;

   typedef struct packed {
      logic [3:0] sync1;
      logic [3:0] sync2;
      logic prevMainRx;
      logic [3:0] mainSel;
      logic [1:0] logSel;
      tuart_tx_t [2:0] tx;
      tuart_rx_t [2:0] rx;
      logic mainKeep;
      logic discard;
      logic ctsN;
      logic wakeIrq;
   } tuart_state_t;

endpackage

//--- rtl/tuart_fifo.sv
// receive buffer with registered output stage
`timescale 1ns/10ps
module tuart_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic inValid,
   input wire logic [WIDTH-1:0] inData,
   output logic inReady,
   output logic outValid,
   output logic [WIDTH-1:0] outData,
   input wire logic outReady,
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wrPtr;
      logic [AW-1:0] rdPtr;
      logic [AW:0] count;
      logic outValid;
      logic [WIDTH-1:0] outData;
   } tuart_fifo_state_t;

   tuart_fifo_state_t s;
   tuart_fifo_state_t next_s;
   logic push;
   logic pop;

   assign inReady = (s.count != (AW+1)'(DEPTH));
   assign outValid = s.outValid;
   assign outData = s.outData;
   assign level = s.count;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_s = s;
      push = inValid && inReady;
      pop = (!s.outValid || outReady) && (s.count != '0);
      if (push) begin
         next_s.mem[s.wrPtr] = inData;
         next_s.wrPtr = s.wrPtr + AW'(1);
      end
      if (s.outValid && outReady) begin
         next_s.outValid = 1'b0;
      end
      // output stage refills in the cycle it drains, so a steady reader sees no gaps
      if (pop) begin
         next_s.outData = s.mem[s.rdPtr];
         next_s.outValid = 1'b1;
         next_s.rdPtr = s.rdPtr + AW'(1);
      end
      next_s.count = s.count + (AW+1)'(push) - (AW+1)'(pop);
      if (reset) begin
         next_s = '0;
      end
   end

   always_ff @(posedge clk_sys) begin
      s <= next_s;
   end
endmodule // tuart_fifo

//--- rtl/tuart_top.sv
// three asynchronous serial ports: primary with flow control and wake, log, auxiliary
`timescale 1ns/10ps
`include "tuart_defines.svh"
module tuart_top (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic mainRxLine,
   output logic mainTxLine,
   output logic mainCtsN,
   input wire logic mainRtsN,
   input wire logic logPortReceiveLine,
   output logic logPortTransmitLine,
   input wire logic auxRxLine,
   output logic auxTxLine,
   input wire tuart_pkg::tuart_byte_t mainTxIn,
   output logic mainTxReady,
   input wire tuart_pkg::tuart_byte_t logTxIn,
   output logic logTxReady,
   input wire tuart_pkg::tuart_byte_t auxTxIn,
   output logic auxTxReady,
   output tuart_pkg::tuart_byte_t mainRxOut,
   input wire logic mainRxTake,
   output tuart_pkg::tuart_byte_t logRxOut,
   output tuart_pkg::tuart_byte_t auxRxOut,
   output logic [2:0] rxFrameErr,
   input wire logic [3:0] mainBaudSel,
   input wire logic mainBaudLoad,
   input wire logic [1:0] logBaudSel,
   input wire logic logBaudLoad,
   input wire logic sleepMode,
   input wire logic wakeEnable,
   output logic wakeIrq
);
   import tuart_pkg::*;

   tuart_state_t s;
   tuart_state_t next_s;
   logic [15:0] div [2:0];
   logic [2:0] txGo;
   logic [7:0] txData [2:0];
   logic [2:0] rxLine;
   logic fifoInReady;
   logic fifoOutValid;
   logic [7:0] fifoOutData;
   logic [5:0] fifoLevel;

   // ----------------------------------------------------------------
   // rate tables
   // ----------------------------------------------------------------
   function automatic logic [15:0] mainDiv(input logic [3:0] sel);
      logic [31:0] d;
      d = `TU_DIV(`TU_BAUD_115200);
      unique case (sel)
         4'h0: d = `TU_DIV(`TU_BAUD_4800);
         4'h1: d = `TU_DIV(`TU_BAUD_9600);
         4'h2: d = `TU_DIV(`TU_BAUD_19200);
         4'h3: d = `TU_DIV(`TU_BAUD_38400);
         4'h4: d = `TU_DIV(`TU_BAUD_57600);
         4'h5: d = `TU_DIV(`TU_BAUD_115200);
         4'h6: d = `TU_DIV(`TU_BAUD_230400);
         4'h7: d = `TU_DIV(`TU_BAUD_460800);
         4'h8: d = `TU_DIV(`TU_BAUD_921600);
         default: d = `TU_DIV(`TU_BAUD_115200);
      endcase
      return d[15:0];
   endfunction

   function automatic logic [15:0] logDiv(input logic [1:0] sel);
      logic [31:0] d;
      d = `TU_DIV(`TU_BAUD_6M);
      unique case (sel)
         2'h0: d = `TU_DIV(`TU_BAUD_115200);
         2'h1: d = `TU_DIV(`TU_BAUD_3M);
         default: d = `TU_DIV(`TU_BAUD_6M);
      endcase
      return d[15:0];
   endfunction

   // ----------------------------------------------------------------
   // framing engines
   // ----------------------------------------------------------------
   // integer division truncates: at 6 Mbps a bit lasts 41 cycles, 1.6 % fast
   function automatic tuart_tx_t txStep(input tuart_tx_t t, input logic go, input logic [7:0] d,
                                        input logic [15:0] dv);
      tuart_tx_t n;
      n = t;
      if (t.idle) begin
         if (go) begin
            n.idle = 1'b0;
            n.line = 1'b0; // RULE9
            n.shift = {1'b1, d};
            n.bitNum = 4'h0;
            n.cnt = dv - 16'h0001;
         end
      end else if (t.cnt != 16'h0000) begin
         n.cnt = t.cnt - 16'h0001;
      end else if (t.bitNum == `TU_STOP_BIT) begin
         n.idle = 1'b1;
         n.line = 1'b1;
      end else begin
         n.line = t.shift[0]; // RULE9
         n.shift = {1'b1, t.shift[8:1]};
         n.bitNum = t.bitNum + 4'h1;
         n.cnt = dv - 16'h0001;
      end
      return n;
   endfunction

   function automatic tuart_rx_t rxStep(input tuart_rx_t r, input logic line, input logic [15:0] dv);
      tuart_rx_t n;
      n = r;
      n.done = 1'b0;
      n.frameErr = 1'b0;
      if (!r.busy) begin
         if (!line) begin
            n.busy = 1'b1;
            n.cnt = {1'b0, dv[15:1]};
            n.bitNum = 4'h0;
         end
      end else if (r.cnt != 16'h0000) begin
         n.cnt = r.cnt - 16'h0001;
      end else if (r.bitNum == 4'h0) begin
         // a glitch shorter than half a bit is not a start bit
         if (line) begin
            n.busy = 1'b0;
         end else begin
            n.bitNum = 4'h1;
            n.cnt = dv - 16'h0001;
         end
      end else if (r.bitNum == `TU_STOP_BIT) begin
         n.busy = 1'b0;
         n.done = line; // RULE9
         n.frameErr = !line;
         if (line) begin
            n.data = r.shift;
         end
      end else begin
         n.shift = {line, r.shift[7:1]}; // RULE9
         n.bitNum = r.bitNum + 4'h1;
         n.cnt = dv - 16'h0001;
      end
      return n;
   endfunction

   // ----------------------------------------------------------------
   // per-port wiring
   // ----------------------------------------------------------------
   always_comb begin
      div[`TU_PORT_MAIN] = mainDiv(s.mainSel); // RULE1
      div[`TU_PORT_LOG] = logDiv(s.logSel); // RULE2
      div[`TU_PORT_AUX] = 16'(`TU_DIV(`TU_BAUD_115200));
      rxLine = s.sync2[2:0];
      txData[`TU_PORT_MAIN] = mainTxIn.data;
      txData[`TU_PORT_LOG] = logTxIn.data;
      txData[`TU_PORT_AUX] = auxTxIn.data;
      // a character is only started while the host holds its request line low
      txGo[`TU_PORT_MAIN] = mainTxIn.valid && !s.sync2[`TU_SYNC_RTS]; // RULE3 RULE5
      txGo[`TU_PORT_LOG] = logTxIn.valid;
      txGo[`TU_PORT_AUX] = auxTxIn.valid;
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_s = s;
      next_s.sync1 = {mainRtsN, auxRxLine, logPortReceiveLine, mainRxLine};
      next_s.sync2 = s.sync1;
      next_s.prevMainRx = s.sync2[`TU_PORT_MAIN];

      // new rate takes effect at the next bit boundary; change it between characters
      if (mainBaudLoad) begin
         next_s.mainSel = mainBaudSel; // RULE1
      end
      if (logBaudLoad) begin
         next_s.logSel = logBaudSel; // RULE2
      end

      for (int p = 0; p < 3; p++) begin
         next_s.tx[p] = txStep(s.tx[p], txGo[p], txData[p], div[p]);
         next_s.rx[p] = rxStep(s.rx[p], rxLine[p], div[p]);
      end

      next_s.wakeIrq = sleepMode && wakeEnable && s.prevMainRx && !s.sync2[`TU_PORT_MAIN]; // RULE6

      // set wins over clear: a wake on the same cycle as a finishing character keeps the flag
      next_s.discard = (next_s.wakeIrq && (s.mainSel > `TU_MAIN_SEL_9600)) // RULE7
                       || (s.discard && !(s.rx[`TU_PORT_MAIN].busy && !next_s.rx[`TU_PORT_MAIN].busy));
      next_s.mainKeep = next_s.rx[`TU_PORT_MAIN].done && !s.discard; // RULE7

      // stop the host a few characters early, it may already have one in flight
      next_s.ctsN = (fifoLevel >= `TU_CTS_STOP_LEVEL); // RULE3 RULE4

      if (reset) begin
         next_s = '0;
         next_s.sync1 = '1;
         next_s.sync2 = '1;
         next_s.prevMainRx = 1'b1;
         next_s.mainSel = `TU_MAIN_SEL_RST; // RULE1
         next_s.logSel = `TU_LOG_SEL_RST; // RULE2
         next_s.ctsN = 1'b1;
         for (int p = 0; p < 3; p++) begin
            next_s.tx[p].idle = 1'b1;
            next_s.tx[p].line = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      s <= next_s;
   end

   // ----------------------------------------------------------------
   // primary receive buffer
   // ----------------------------------------------------------------
   // a character arriving while full is lost; flow control keeps that from happening
   tuart_fifo #(
      .WIDTH(`TU_FIFO_WIDTH),
      .DEPTH(`TU_FIFO_DEPTH)
   ) u_rxFifo (
      .clk_sys(clk_sys),
      .reset(reset),
      .inValid(s.mainKeep),
      .inData(s.rx[`TU_PORT_MAIN].data),
      .inReady(fifoInReady),
      .outValid(fifoOutValid),
      .outData(fifoOutData),
      .outReady(mainRxTake),
      .level(fifoLevel)
   );

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign mainTxLine = s.tx[`TU_PORT_MAIN].line;
   assign logPortTransmitLine = s.tx[`TU_PORT_LOG].line;
   assign auxTxLine = s.tx[`TU_PORT_AUX].line;
   assign mainTxReady = s.tx[`TU_PORT_MAIN].idle;
   assign logTxReady = s.tx[`TU_PORT_LOG].idle;
   assign auxTxReady = s.tx[`TU_PORT_AUX].idle;
   assign mainCtsN = s.ctsN; // RULE4
   assign mainRxOut = '{valid: fifoOutValid, data: fifoOutData};
   assign logRxOut = '{valid: s.rx[`TU_PORT_LOG].done, data: s.rx[`TU_PORT_LOG].data};
   assign auxRxOut = '{valid: s.rx[`TU_PORT_AUX].done, data: s.rx[`TU_PORT_AUX].data};
   assign rxFrameErr = {s.rx[`TU_PORT_AUX].frameErr, s.rx[`TU_PORT_LOG].frameErr, s.rx[`TU_PORT_MAIN].frameErr};
   assign wakeIrq = s.wakeIrq; // RULE6
endmodule // tuart_top

//--- testbench/tuart_checker.sv
// port assertions for the triple serial port block
`timescale 1ns/10ps
module tuart_checker (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic mainRxLine,
   input wire logic mainTxLine,
   input wire logic mainCtsN,
   input wire logic mainRtsN,
   input wire logic mainTxReady,
   input wire logic logPortTransmitLine,
   input wire logic logTxReady,
   input wire tuart_pkg::tuart_byte_t logTxIn,
   input wire logic auxTxLine,
   input wire logic auxTxReady,
   input wire tuart_pkg::tuart_byte_t mainRxOut,
   input wire logic sleepMode,
   input wire logic wakeEnable,
   input wire logic wakeIrq
);
   import tuart_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   // ----
   // frame steps
   // ----
   sequence logTake;
      logTxIn.valid && logTxReady;
   endsequence
   sequence logStartBit;
      !logTxReady && !logPortTransmitLine;
   endsequence
   a_reset_idle_lines: assert property (disable iff (1'b0) reset |=>
      mainTxLine && logPortTransmitLine && auxTxLine && mainCtsN && !wakeIrq) else $error("not idle in reset");
   a_log_start_bit: assert property (logTake |=> logStartBit)
      else $error("log start bit late");
   a_aux_start_low: assert property ($fell(auxTxReady) |-> !auxTxLine)
      else $error("aux start bit missing");
   a_idle_line_high: assert property ((mainTxReady |-> mainTxLine) and (auxTxReady |-> auxTxLine))
      else $error("idle line low");
   // two sync flops, so three high samples must block a start
   a_rts_blocks_tx: assert property (mainRtsN [*3] ##0 mainTxReady |=> mainTxReady)
      else $error("sent while host busy");
   a_cts_full_out: assert property ($rose(mainCtsN) |-> mainRxOut.valid)
      else $error("stop raised with empty output");
   a_cts_after_reset: assert property ($fell(reset) |-> ##[1:2] !mainCtsN)
      else $error("stop held after reset");
   a_wake_on_fall: assert property ($fell(mainRxLine) && sleepMode && wakeEnable |-> ##[2:3] wakeIrq)
      else $error("wake missing");
   a_wake_cause: assert property (wakeIrq |-> !$past(mainRxLine, 2))
      else $error("wake without line low");
   a_wake_one_cycle: assert property (wakeIrq |=> !wakeIrq)
      else $error("wake pulse too long");
endmodule // tuart_checker

//--- testbench/tuart_host_model.sv
// host controller partner on the primary port
`timescale 1ns/10ps
module tuart_host_model (
   input wire logic clk_sys,
   input wire logic txLine,
   input wire logic ctsN,
   input wire logic [31:0] div,
   output logic rxLine,
   output logic rtsN,
   output logic gotValid,
   output logic [7:0] gotData
);
   initial begin
      rxLine = 1'b1;
      rtsN = 1'b0;
      gotValid = 1'b0;
      gotData = 8'h00;
   end
   task automatic send(input logic [7:0] b, output bit late);
      logic [9:0] f;
      int n;
      f = {1'b1, b, 1'b0};
      n = 0;
      // only looked at between characters, as a real host does
      while (ctsN && n < 20000) begin
         @(posedge clk_sys);
         n++;
      end
      late = (n >= 20000);
      for (int i = 0; i < 10; i++) begin
         rxLine <= f[i];
         repeat (div) @(posedge clk_sys);
      end
   endtask
   always @(posedge clk_sys) begin
      gotValid <= 1'b0;
      if (!txLine) begin
         repeat (div / 2) @(posedge clk_sys);
         for (int i = 0; i < 8; i++) begin
            repeat (div) @(posedge clk_sys);
            gotData[i] <= txLine;
         end
         repeat (div) @(posedge clk_sys);
         gotValid <= txLine;
      end
   end
endmodule // tuart_host_model

//--- testbench/tuart_top_tb.sv
// self-checking bench for the triple serial port block
`timescale 1ns/10ps
module tuart_top_tb;
   import tuart_pkg::*;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic mainRxTake = 1'b1;
   logic [3:0] mainBaudSel = 4'h0;
   logic mainBaudLoad = 1'b0;
   logic [1:0] logBaudSel = 2'h0;
   logic logBaudLoad = 1'b0;
   logic sleepMode = 1'b0;
   logic wakeEnable = 1'b0;
   tuart_byte_t txIn [3] = '{default: '0};
   tuart_byte_t mainRxOut, logRxOut, auxRxOut;
   logic mainRxLine, mainTxLine, mainCtsN, mainRtsN, logLine, auxLine, wakeIrq, gotValid;
   logic [2:0] rdy;
   logic [7:0] gotData;
   logic [7:0] seed = 8'h55;
   logic [7:0] q [4][$];
   int hostDiv = 2170;
   int ldiv [3] = '{2170, 83, 41};
   int errors = 0;
   int num_checks = 0;
   int wakes = 0;
   int ferrs = 0;
   logic [2:0] frameErr;
   string nm [4] = '{"mainRx", "logRx", "auxRx", "hostRx"};
   always #2 clk_sys = ~clk_sys;
   tuart_top dut (.clk_sys, .reset, .mainRxLine, .mainTxLine, .mainCtsN, .mainRtsN,
      .logPortReceiveLine(logLine), .logPortTransmitLine(logLine), .auxRxLine(auxLine), .auxTxLine(auxLine),
      .mainTxIn(txIn[0]), .mainTxReady(rdy[0]), .logTxIn(txIn[1]), .logTxReady(rdy[1]), .auxTxIn(txIn[2]),
      .auxTxReady(rdy[2]), .mainRxOut, .mainRxTake, .logRxOut, .auxRxOut, .rxFrameErr(frameErr), .mainBaudSel,
      .mainBaudLoad, .logBaudSel, .logBaudLoad, .sleepMode, .wakeEnable, .wakeIrq);
   tuart_host_model host (.clk_sys, .txLine(mainTxLine), .ctsN(mainCtsN), .div(hostDiv), .rxLine(mainRxLine),
      .rtsN(mainRtsN), .gotValid, .gotData);
   // ----
   // helpers
   // ----
   function automatic logic [7:0] rnd();
      seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
      return seed;
   endfunction
   task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic take(input int p, input logic [7:0] got);
      logic [7:0] e;
      e = 8'hxx;
      if (q[p].size() > 0) e = q[p].pop_front();
      chk(nm[p], got, e);
   endtask
   // held until ready drops: ready means idle, not taken
   task automatic put(input int p, input logic [7:0] b);
      int n;
      n = 0;
      q[p == 0 ? 3 : p].push_back(b);
      txIn[p] <= '{1'b1, b};
      do begin
         @(posedge clk_sys);
         n++;
      end while (rdy[p] !== 1'b0 && n < 30000);
      txIn[p] <= '0;
      if (n >= 30000) errors++;
   endtask
   task automatic hsend(input logic [7:0] b, input bit keep);
      bit late;
      if (keep) q[0].push_back(b);
      host.send(b, late);
      if (late) errors++;
   endtask
   task automatic give_verdict();
      if (errors == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      if (mainRxOut.valid === 1'b1 && mainRxTake) take(0, mainRxOut.data);
      if (logRxOut.valid === 1'b1) take(1, logRxOut.data);
      if (auxRxOut.valid === 1'b1) take(2, auxRxOut.data);
      if (gotValid === 1'b1) take(3, gotData);
      if (wakeIrq === 1'b1) wakes++;
      if (!reset && frameErr !== 3'b000) ferrs++;
   end
   initial begin
      repeat (115000) @(posedge clk_sys);
      errors++;
      give_verdict();
   end
   // ----
   // main sequence
   // ----
   initial begin
      repeat (4) @(posedge clk_sys);
      chk("idle", {mainTxLine, logLine, auxLine, mainCtsN, wakeIrq}, 8'h1E);
      reset <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk("ctsN", mainCtsN, 1'b0);
      fork
         begin
            put(0, rnd());
            repeat (21000) @(posedge clk_sys);
         end
         hsend(rnd(), 1'b1);
      join
      mainBaudSel <= 4'h8;
      mainBaudLoad <= 1'b1;
      hostDiv <= 271;
      host.rtsN <= 1'b1;
      @(posedge clk_sys);
      mainBaudLoad <= 1'b0;
      // the request line needs two synchroniser edges before it can hold off a start
      repeat (2) @(posedge clk_sys);
      mainRxTake <= 1'b0;
      // log and auxiliary ports share nothing with the primary one, so they ride along with the fill
      fork
         put(2, rnd());
         for (int i = 2; i >= 0; i--) begin
            put(1, rnd());
            repeat (11 * ldiv[i]) @(posedge clk_sys);
            logBaudSel <= 2'(i - 1);
            logBaudLoad <= 1'b1;
            @(posedge clk_sys);
            logBaudLoad <= 1'b0;
         end
         put(0, rnd());
         begin
            repeat (300) @(posedge clk_sys);
            chk("refuse", {rdy[0], mainTxLine}, 8'h03);
            host.rtsN <= 1'b0;
         end
         for (int i = 0; i < 30; i++) hsend(rnd(), 1'b1);
         begin
            repeat (29 * 2710 + 100) @(posedge clk_sys);
            chk("ctsFull", mainCtsN, 1'b1);
            mainRxTake <= 1'b1;
         end
      join
      sleepMode <= 1'b1;
      wakeEnable <= 1'b1;
      hsend(8'h00, 1'b0);
      wakeEnable <= 1'b0;
      hsend(rnd(), 1'b1);
      sleepMode <= 1'b0;
      repeat (40) @(posedge clk_sys);
      for (int p = 0; p < 4; p++) chk(nm[p], 8'(q[p].size()), 8'h00);
      chk("wakes", 8'(wakes), 8'h01);
      chk("frameErr", 8'(ferrs), 8'h00);
      chk("ctsN", mainCtsN, 1'b0);
      give_verdict();
   end
endmodule // tuart_top_tb
bind tuart_top tuart_checker chk_i (.clk_sys, .reset, .mainRxLine, .mainTxLine, .mainCtsN, .mainRtsN, .mainTxReady,
   .logPortTransmitLine, .logTxReady, .logTxIn, .auxTxLine, .auxTxReady, .mainRxOut, .sleepMode, .wakeEnable,
   .wakeIrq);
